// ---- rtcpc_flag.sv ----
// Purpose: Sticky status flag, hardware set, write-one clear
// Assumes: Set and clear are single pclk pulses
// Notes: A set in the clearing cycle wins
`timescale 1ns/1ps
module rtcpc_flag (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Async reset, active low
    input wire logic set, // Hardware event
    input wire logic clr, // Software clear
    output logic q // Flag state
);
    // Set has priority over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end
endmodule : rtcpc_flag

// ---- rtcpc_pkg.sv ----
// Purpose: Shared constants for the real-time counter with periodic timer
// Assumes: APB slave, 32-bit data, one word per register
// Notes: Byte offsets are word aligned; all fields sit in low bits
package rtcpc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_CTRL = 8'h08;
    localparam logic [7:0] OFS_IRQ_FLAGS = 8'h0C;
    localparam logic [7:0] OFS_CRYSTAL_CALIBRATION = 8'h10;
    localparam logic [7:0] OFS_CLOCK_SOURCE_SELECT = 8'h14;
    localparam logic [7:0] OFS_CNT = 8'h18;
    localparam logic [7:0] OFS_PER = 8'h1C;
    localparam logic [7:0] OFS_CMP = 8'h20;
    localparam logic [7:0] OFS_PIT_CTRL = 8'h24;
    localparam logic [7:0] OFS_PIT_IRQ_CTRL = 8'h28;
    localparam logic [7:0] OFS_PIT_FLAGS = 8'h2C;
    // Field positions
    localparam int BIT_EN = 0;
    localparam int BIT_CORR_EN = 2;
    localparam int POS_PRESC = 3;
    localparam int POS_PIT_PERIOD = 3;
    localparam int BIT_OVF = 0;
    localparam int BIT_CMP = 1;
    localparam int BIT_SIGN = 7;
    // Reset values
    localparam logic [15:0] RST_PER = 16'hFFFF;
    localparam logic [15:0] RST_CMP = 16'h0000;
    localparam logic [3:0] RST_PRESC = 4'h0;
    // Correction: error spread over one million reference cycles
    localparam logic [19:0] CORR_SPAN = 20'hF4240;
    localparam logic [6:0] CORR_MAX = 7'h7F;
    // Periodic timer: period codes 1..14 select 4..32768 cycles
    localparam logic [3:0] PIT_CODE_MIN = 4'h1;
    localparam logic [3:0] PIT_CODE_MAX = 4'hE;
    // Level event taps: prescaler bit 5 is divide by 64, bit 12 by 8192
    localparam int EVT_TAP_LO = 5;
    localparam int EVT_TAP_HI = 12;
    localparam logic [4:0] OSC_DIV_LAST = 5'h1F;
    // Clock source codes
    typedef enum logic [1:0] {
        RTCPC_SRC_XTAL = 2'h0,
        RTCPC_SRC_EXTCLK = 2'h1,
        RTCPC_SRC_OSC = 2'h2,
        RTCPC_SRC_OSC_DIV32 = 2'h3
    } rtcpc_src_t;
endpackage : rtcpc_pkg

// ---- rtcpc_sync.sv ----
// Purpose: Two-flop synchroniser with rising edge pulse
// Assumes: Input is a slow clock from a pin, far below pclk
// Notes: First flop feeds only the second flop
`timescale 1ns/1ps
module rtcpc_sync (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Async reset, active low
    input wire logic async_in, // Pin level
    output logic rise // One-cycle pulse per rising edge
);
    logic s1;
    logic s2;
    logic s3;

    // Synchroniser chain and edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            rise <= 1'b0;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            rise <= s2 & ~s3;
        end
    end
endmodule : rtcpc_sync

// ---- rtcpc_top.sv ----
// Purpose: Real-time counter and periodic timer behind an APB slave
// Assumes: Counter clock sources are pins far slower than pclk
// Notes: pclk must run at least four times the counter clock
//
// Summary of operation
// - 16-bit counter compared against period and compare
// - Compare flag/event on tick after match
// - Overflow flag/event and wrap after period match
// - Clock from crystal, ext clock, osc, osc/32
// - 15-bit prescaler ahead of the counter
// - Correction in 1 ppm steps, 127 max
// - Correction skips or inserts prescaler counts
// - Periodic timer fires at power-of-two periods
// - Periodic timer independent of counter
// - Counter enable bit starts and stops counter
// - Periodic enable bit starts and stops timer
// - Shared prescaler runs while either enabled
// - First tick lands within one period
// - Periodic output toggles every half period
// - Correction enable applies calibration error value
// - Error cycles spread over one million cycles
// - Correction seen in count and periodic timer
// - Ongoing correction completes after disable
// - Events fire exactly with their flags
// - Interrupt held while enable and flag set
`timescale 1ns/1ps
module rtcpc_top
    import rtcpc_pkg::*;
(
    input wire logic pclk, // APB clock, 40 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic xtal_clk_in, // Crystal oscillator clock
    input wire logic ext_clk_in, // External digital clock
    input wire logic osc_clk_in, // Internal low-frequency oscillator
    output logic counter_irq, // Overflow or compare request
    output logic periodic_irq, // Periodic timer request
    output logic overflow_event, // Overflow event pulse
    output logic compare_event, // Compare event pulse
    output logic [7:0] periodic_event // Level events, div 64 to 8192
);
    logic counter_enable_bit;
    logic correction_enable;
    logic [3:0] presc;
    logic overflow_irq_en;
    logic compare_irq_en;
    logic [7:0] crystal_calibration;
    rtcpc_src_t clock_source_select;
    logic [15:0] cnt;
    logic [15:0] per;
    logic [15:0] cmp;
    logic periodic_timer_enable;
    logic [3:0] pit_period;
    logic periodic_irq_enable;
    logic [14:0] pre;
    logic [19:0] corr_acc;
    logic corr_pending;
    logic [4:0] osc_div;
    logic osc_div_tick;
    logic xtal_rise;
    logic ext_rise;
    logic osc_rise;
    logic ref_tick;
    logic pre_run;
    logic [1:0] pre_inc;
    logic [15:0] pre_mask;
    logic count_tick;
    logic ovf_set;
    logic cmp_set;
    logic ovf_flag;
    logic cmp_flag;
    logic pit_flag;
    logic pit_lvl;
    logic pit_q;
    logic pit_rise;
    logic wr_done;
    logic rd_start;
    logic mapped;
    logic [20:0] acc_sum;
    logic [31:0] next_rdata;

    // Pin clocks into the pclk domain
    rtcpc_sync u_sync_xtal (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(xtal_clk_in),
        .rise(xtal_rise)
    );
    rtcpc_sync u_sync_ext (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(ext_clk_in),
        .rise(ext_rise)
    );
    rtcpc_sync u_sync_osc (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(osc_clk_in),
        .rise(osc_rise)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_div <= 5'h00;
        end else if (osc_rise) begin
            osc_div <= osc_div + 5'h01;
        end
    end
    assign osc_div_tick = osc_rise && (osc_div == OSC_DIV_LAST);

    always_comb begin
        case (clock_source_select)
            RTCPC_SRC_XTAL: ref_tick = xtal_rise;
            RTCPC_SRC_EXTCLK: ref_tick = ext_rise;
            RTCPC_SRC_OSC: ref_tick = osc_rise;
            RTCPC_SRC_OSC_DIV32: ref_tick = osc_div_tick;
            default: ref_tick = 1'b0;
        endcase
    end

    // APB handshake: one wait state, then ready
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_PIT_FLAGS);
    assign rd_start = psel && penable && !pready;
    assign wr_done = psel && penable && pready && pwrite && mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= rd_start;
            pslverr <= rd_start && !mapped;
            prdata <= (rd_start && !pwrite) ? next_rdata : 32'h0000_0000;
        end
    end

    // Read multiplexer
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (paddr)
            OFS_CTRL: next_rdata = {25'h0, presc, correction_enable, 1'b0,
                                    counter_enable_bit};
            OFS_STATUS: next_rdata = {30'h0, corr_pending, pre_run};
            OFS_IRQ_CTRL: next_rdata = {30'h0, compare_irq_en, overflow_irq_en};
            OFS_IRQ_FLAGS: next_rdata = {30'h0, cmp_flag, ovf_flag};
            OFS_CRYSTAL_CALIBRATION: next_rdata = {24'h0, crystal_calibration};
            OFS_CLOCK_SOURCE_SELECT: next_rdata = {30'h0, clock_source_select};
            OFS_CNT: next_rdata = {16'h0, cnt};
            OFS_PER: next_rdata = {16'h0, per};
            OFS_CMP: next_rdata = {16'h0, cmp};
            OFS_PIT_CTRL: next_rdata = {25'h0, pit_period, 2'h0, periodic_timer_enable};
            OFS_PIT_IRQ_CTRL: next_rdata = {31'h0, periodic_irq_enable};
            OFS_PIT_FLAGS: next_rdata = {31'h0, pit_flag};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Control register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_enable_bit <= 1'b0;
            correction_enable <= 1'b0;
            presc <= RST_PRESC;
            overflow_irq_en <= 1'b0;
            compare_irq_en <= 1'b0;
            crystal_calibration <= 8'h00;
            clock_source_select <= RTCPC_SRC_XTAL;
            per <= RST_PER;
            cmp <= RST_CMP;
            periodic_timer_enable <= 1'b0;
            pit_period <= 4'h0;
            periodic_irq_enable <= 1'b0;
        end else if (wr_done) begin
            case (paddr)
                OFS_CTRL: begin
                    counter_enable_bit <= pwdata[BIT_EN];
                    correction_enable <= pwdata[BIT_CORR_EN];
                    presc <= pwdata[POS_PRESC +: 4];
                end
                OFS_IRQ_CTRL: begin
                    overflow_irq_en <= pwdata[BIT_OVF];
                    compare_irq_en <= pwdata[BIT_CMP];
                end
                OFS_CRYSTAL_CALIBRATION: crystal_calibration <= pwdata[7:0];
                OFS_CLOCK_SOURCE_SELECT: clock_source_select <= rtcpc_src_t'(pwdata[1:0]);
                OFS_PER: per <= pwdata[15:0];
                OFS_CMP: cmp <= pwdata[15:0];
                OFS_PIT_CTRL: begin
                    periodic_timer_enable <= pwdata[BIT_EN];
                    pit_period <= pwdata[POS_PIT_PERIOD +: 4];
                end
                OFS_PIT_IRQ_CTRL: periodic_irq_enable <= pwdata[BIT_EN];
                default: ;
            endcase
        end
    end

    // prescaler runs while either function enabled
    assign pre_run = counter_enable_bit || periodic_timer_enable;
    // skip a count to speed up, hold to slow down
    assign pre_inc = !corr_pending ? 2'h1 : (crystal_calibration[BIT_SIGN] ? 2'h0 : 2'h2);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre <= 15'h0000;
        end else if (!pre_run) begin
            pre <= 15'h0000;
        end else if (ref_tick) begin
            pre <= pre + {13'h0, pre_inc};
        end
    end

    assign acc_sum = {1'b0, corr_acc} + {14'h0, crystal_calibration[6:0]};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            corr_acc <= 20'h00000;
            corr_pending <= 1'b0;
        end else if (pre_run && ref_tick) begin
            if (correction_enable && acc_sum >= {1'b0, CORR_SPAN}) begin
                corr_acc <= 20'(acc_sum - {1'b0, CORR_SPAN});
                corr_pending <= 1'b1;
            end else begin
                if (correction_enable) begin
                    corr_acc <= acc_sum[19:0];
                end
                corr_pending <= 1'b0;
            end
        end
    end

    assign pre_mask = (16'h0001 << presc) - 16'h0001;
    // corrected prescaler drives the count tick
    assign count_tick = counter_enable_bit && ref_tick &&
        ((({1'b0, pre} & pre_mask) + {14'h0, pre_inc}) > pre_mask);

    // compare match seen at the next tick
    assign cmp_set = count_tick && (cnt == cmp);
    // period match seen at the next tick
    assign ovf_set = count_tick && (cnt == per);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 16'h0000;
        end else if (wr_done && paddr == OFS_CNT) begin
            cnt <= pwdata[15:0];
        end else if (ovf_set) begin
            cnt <= 16'h0000;
        end else if (count_tick) begin
            cnt <= cnt + 16'h0001;
        end
    end

    // Sticky flags, write one to clear
    rtcpc_flag u_flag_ovf (
        .pclk(pclk),
        .presetn(presetn),
        .set(ovf_set),
        .clr(wr_done && paddr == OFS_IRQ_FLAGS && pwdata[BIT_OVF]),
        .q(ovf_flag)
    );
    rtcpc_flag u_flag_cmp (
        .pclk(pclk),
        .presetn(presetn),
        .set(cmp_set),
        .clr(wr_done && paddr == OFS_IRQ_FLAGS && pwdata[BIT_CMP]),
        .q(cmp_flag)
    );
    rtcpc_flag u_flag_pit (
        .pclk(pclk),
        .presetn(presetn),
        .set(pit_rise),
        .clr(wr_done && paddr == OFS_PIT_FLAGS && pwdata[BIT_EN]),
        .q(pit_flag)
    );

    // periodic output is a prescaler bit, toggling each half period
    always_comb begin
        pit_lvl = 1'b0;
        // code k gives a period of 2^(k+1) cycles
        if (periodic_timer_enable && pit_period >= PIT_CODE_MIN
                && pit_period <= PIT_CODE_MAX) begin
            pit_lvl = pre[pit_period];
        end
    end
    assign pit_rise = pit_lvl && !pit_q;

    // periodic timer state, independent of counter enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pit_q <= 1'b0;
            periodic_event <= 8'h00;
        end else begin
            pit_q <= pit_lvl;
            periodic_event <= periodic_timer_enable ? pre[EVT_TAP_HI:EVT_TAP_LO] : 8'h00;
        end
    end

    // events and requests from flop outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_event <= 1'b0;
            compare_event <= 1'b0;
            counter_irq <= 1'b0;
            periodic_irq <= 1'b0;
        end else begin
            overflow_event <= ovf_set;
            compare_event <= cmp_set;
            // request while flag and enable set
            counter_irq <= (ovf_flag && overflow_irq_en) || (cmp_flag && compare_irq_en);
            periodic_irq <= pit_flag && periodic_irq_enable;
        end
    end

    // Checks on counter, prescaler, flags and bus
    // wrap and flag
    a_ovf_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        ovf_set && !(wr_done && paddr == OFS_CNT) |=> cnt == 16'h0000 && ovf_flag)
        else $error("overflow did not wrap counter");
    a_cmp_flag: assert property (@(posedge pclk) disable iff (!presetn)
        cmp_set |=> cmp_flag ##1 cmp_flag || $past(wr_done))
        else $error("compare flag not set");
    a_pre_stop: assert property (@(posedge pclk) disable iff (!presetn)
        !pre_run |=> pre == 15'h0000)
        else $error("prescaler ran while both disabled");
    a_cnt_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !counter_enable_bit && !wr_done |=> $stable(cnt))
        else $error("counter moved while disabled");
    a_event_match: assert property (@(posedge pclk) disable iff (!presetn)
        overflow_event == $past(ovf_set) && compare_event == $past(cmp_set))
        else $error("event differs from flag condition");
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        ovf_flag && overflow_irq_en |=> counter_irq)
        else $error("counter request missing");
    a_pit_fire: assert property (@(posedge pclk) disable iff (!presetn)
        pit_rise |=> pit_flag ##1 (periodic_irq || !periodic_irq_enable || !pit_flag))
        else $error("periodic flag or request missing");
    a_corr_finish: assert property (@(posedge pclk) disable iff (!presetn)
        corr_pending && !ref_tick |=> corr_pending)
        else $error("correction dropped before applied");
    a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
        rd_start |=> pready ##1 !pready || (psel && penable && !pready))
        else $error("ready not one wait state");
    c_overflow: cover property (@(posedge pclk) disable iff (!presetn) ovf_set);
    c_pit_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(periodic_irq));
    c_correction: cover property (@(posedge pclk) disable iff (!presetn)
        corr_pending && ref_tick);
endmodule : rtcpc_top

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the real-time counter with periodic timer
// Assumes: Pin clocks made here at a fixed pclk ratio, far below pclk
// Notes: Intervals are measured in pclk cycles between rising edges of outputs, except the level event half period, rising to falling
`timescale 1ns/1ps
module tb_top;
    import rtcpc_pkg::*;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic xtal_clk_in;
    logic ext_clk_in;
    logic osc_clk_in;
    logic counter_irq;
    logic periodic_irq;
    logic overflow_event;
    logic compare_event;
    logic [7:0] periodic_event;
    logic [31:0] rdat;
    logic [31:0] cval;
    logic err;
    int fails;
    int check_count;
    int cyc;
    int t0;
    int t1;
    // Reference period per clock source, in pclk cycles
    int ref_per[4] = '{8, 12, 6, 192};

    rtcpc_top rtcpc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .xtal_clk_in(xtal_clk_in),
        .ext_clk_in(ext_clk_in), .osc_clk_in(osc_clk_in), .counter_irq(counter_irq),
        .periodic_irq(periodic_irq), .overflow_event(overflow_event),
        .compare_event(compare_event), .periodic_event(periodic_event));

    // Bus clock, 25 ns period
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Cycle count and pin clocks, changed just after each rising edge
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc % 4 == 0) xtal_clk_in <= ~xtal_clk_in;
        if (cyc % 6 == 0) ext_clk_in <= ~ext_clk_in;
        if (cyc % 3 == 0) osc_clk_in <= ~osc_clk_in;
    end

    task automatic report_and_stop();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                       output logic [31:0] rd, output logic er);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fails++;
            report_and_stop();
        end
    endtask : apb

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] d;
        logic e;
        apb(1'b1, addr, data, d, e);
    endtask : wr

    task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic e;
        apb(1'b0, addr, 32'h0, d, e);
        chk(d, exp, what);
        chk({31'h0, e}, 32'h0, "error flag");
    endtask : rdchk

    function automatic logic ev(input int sel);
        case (sel)
            0: return overflow_event;
            1: return compare_event;
            2: return periodic_irq;
            3: return periodic_event[0];
            default: return ~periodic_event[0];
        endcase
    endfunction : ev

    // Bounded wait for a rising edge of the selected output
    task automatic wait_ev(input int sel, output int t);
        logic prev;
        int n;
        prev = ev(sel);
        for (n = 0; n < 3000; n++) begin
            @(posedge pclk);
            if (ev(sel) === 1'b1 && prev !== 1'b1) break;
            prev = ev(sel);
        end
        t = cyc;
        if (n >= 3000) begin
            fails++;
            report_and_stop();
        end
    endtask : wait_ev

    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        xtal_clk_in = 1'b0;
        ext_clk_in = 1'b0;
        osc_clk_in = 1'b0;
        cyc = 0;
        fails = 0;
        check_count = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(OFS_CTRL, 32'h0, "control reset");
        rdchk(OFS_PER, 32'h0000FFFF, "period reset");
        rdchk(OFS_CMP, 32'h0, "compare reset");
        rdchk(OFS_STATUS, 32'h0, "prescaler idle");
        apb(1'b0, 8'h30, 32'h0, rdat, err);
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk(rdat, 32'h0, "unmapped data");
        wr(OFS_CRYSTAL_CALIBRATION, 32'h000000FF);
        rdchk(OFS_CRYSTAL_CALIBRATION, 32'h000000FF, "calibration");
        $display("test registers done");
        wr(OFS_CMP, 32'h1);
        wr(OFS_PER, 32'h3);
        wr(OFS_IRQ_CTRL, 32'h3);
        wr(OFS_CLOCK_SOURCE_SELECT, 32'h0);
        wr(OFS_CTRL, 32'h1);
        for (int s = 1; s <= 4; s++) begin
            wr(OFS_CLOCK_SOURCE_SELECT, 32'(s % 4));
            repeat (2) wait_ev(0, t0);
            wait_ev(0, t1);
            chk(32'(t1 - t0), 32'(4 * ref_per[s % 4]), "overflow interval");
        end
        $display("test clock sources done");
        wait_ev(1, t0);
        wait_ev(0, t1);
        chk(32'(t1 - t0), 32'd16, "compare to overflow");
        rdchk(OFS_IRQ_FLAGS, 32'h3, "flags set");
        wr(OFS_CTRL, 32'h0);
        chk({31'h0, counter_irq}, 32'h1, "counter request held");
        apb(1'b0, OFS_CNT, 32'h0, cval, err);
        repeat (40) @(posedge pclk);
        rdchk(OFS_CNT, cval, "count frozen");
        wr(OFS_IRQ_FLAGS, 32'h3);
        repeat (3) @(posedge pclk);
        chk({31'h0, counter_irq}, 32'h0, "counter request cleared");
        rdchk(OFS_IRQ_FLAGS, 32'h0, "flags cleared");
        $display("test counter done");
        wr(OFS_CTRL, 32'h11);
        repeat (2) wait_ev(0, t0);
        wait_ev(0, t1);
        chk(32'(t1 - t0), 32'd128, "prescaled interval");
        wr(OFS_CTRL, 32'h0);
        // Count left by the prescaler test, must not move while only the timer runs
        apb(1'b0, OFS_CNT, 32'h0, cval, err);
        $display("test prescaler done");
        wr(OFS_PIT_IRQ_CTRL, 32'h1);
        wr(OFS_PIT_CTRL, 32'h9);
        rdchk(OFS_STATUS, 32'h1, "prescaler running");
        wait_ev(2, t0);
        repeat (40) @(posedge pclk);
        chk({31'h0, periodic_irq}, 32'h1, "periodic request held");
        wr(OFS_PIT_FLAGS, 32'h1);
        repeat (3) @(posedge pclk);
        chk({31'h0, periodic_irq}, 32'h0, "periodic request cleared");
        wait_ev(2, t1);
        chk(32'(t1 - t0), 32'd64, "periodic interval");
        rdchk(OFS_CNT, cval, "count idle");
        wait_ev(3, t0);
        wait_ev(4, t1);
        chk(32'(t1 - t0), 32'd256, "level event half period");
        wr(OFS_PIT_CTRL, 32'h0);
        repeat (5) @(posedge pclk);
        chk({24'h0, periodic_event}, 32'h0, "level events stopped");
        rdchk(OFS_STATUS, 32'h0, "prescaler stopped");
        $display("test periodic timer done");
        // Slow correction on osc, divide by two; poll until one correction is pending
        wr(OFS_CLOCK_SOURCE_SELECT, 32'h2);
        wr(OFS_CRYSTAL_CALIBRATION, 32'h000000FF);
        wr(OFS_CTRL, 32'h0000000D);
        rdat = 32'h0;
        for (int n = 0; n < 15000 && rdat[1] !== 1'b1; n++) begin
            apb(1'b0, OFS_STATUS, 32'h0, rdat, err);
        end
        chk(rdat, 32'h3, "correction pending");
        wr(OFS_CTRL, 32'h0);
        $display("test correction done");
        report_and_stop();
    end
endmodule : tb_top
